// *** arch_state_pkg.sv ***
// constants, field positions and cause codes for the architectural state block
// assumes 32-bit words numbered big-endian: bit 0 is the most significant bit
package arch_state_pkg;
	// special register selector codes
	localparam logic [15:0] SEL_PC = 16'h0000;
	localparam logic [15:0] SEL_MSR = 16'h0001;
	localparam logic [15:0] SEL_EAR = 16'h0003;
	localparam logic [15:0] SEL_ESR = 16'h0005;
	// status register field positions, big-endian numbering
	localparam int CC_B = 0;
	localparam int VMS_B = 17;
	localparam int VM_B = 18;
	localparam int UMS_B = 19;
	localparam int UM_B = 20;
	localparam int PVR_B = 21;
	localparam int EIP_B = 22;
	localparam int EE_B = 23;
	localparam int DCE_B = 24;
	localparam int DZO_B = 25;
	localparam int ICE_B = 26;
	localparam int STE_B = 27;
	localparam int BIP_B = 28;
	localparam int C_B = 29;
	localparam int IE_B = 30;
	localparam int RSV_B = 31;
	// fault status field positions
	localparam int DS_B = 19;
	localparam int WACC_B = 20;
	localparam int EC_LO = 27;
	localparam int EC_HI = 31;
	// reset values, and the register file's configuration load value
	localparam logic [0:31] PC_RST = 32'h00000000;
	localparam logic [0:31] MSR_RST = 32'h00000000;
	localparam logic [0:31] EAR_RST = 32'h00000000;
	localparam logic [0:31] ESR_RST = 32'h00000000;
	localparam logic [0:31] GPR_INIT = 32'h00000000;
	// registers loaded with return addresses, and the zero register
	localparam logic [4:0] INT_RET_REG = 5'h0e;
	localparam logic [4:0] BRK_RET_REG = 5'h10;
	localparam logic [4:0] EXC_RET_REG = 5'h11;
	localparam logic [4:0] ZERO_REG = 5'h00;
	// exception cause codes
	typedef enum logic [4:0] {
		CAUSE_STREAM = 5'h00,
		CAUSE_UNALIGN = 5'h01,
		CAUSE_ILLEGAL = 5'h02,
		CAUSE_IBUS = 5'h03,
		CAUSE_DBUS = 5'h04,
		CAUSE_DIVIDE = 5'h05,
		CAUSE_FPU = 5'h06,
		CAUSE_PRIV = 5'h07,
		CAUSE_DSTORE = 5'h10,
		CAUSE_ISTORE = 5'h11,
		CAUSE_DMISS = 5'h12,
		CAUSE_IMISS = 5'h13
	} cause_t;
	// stack protection shares the privileged code
	localparam logic [4:0] CAUSE_STACK = 5'h07;

	// causes that record the faulting address
	function automatic logic capturesAddr(input logic [4:0] c);
		return c == CAUSE_UNALIGN || c == CAUSE_DBUS || c[4];
	endfunction : capturesAddr
endpackage : arch_state_pkg

// *** fault_if.sv ***
// bundle carrying an exception event to the fault capture registers
// assumes one exception event per cycle at most
`timescale 1ns/100ps
interface fault_if;
	logic take;
	logic [4:0] cause;
	logic [0:31] addr;
	logic inDelay;
	logic wordAcc;
	logic [0:31] fault_address;
	logic [0:31] fault_status;
	modport core (output take, cause, addr, inDelay, wordAcc, input fault_address, fault_status);
	modport capt (input take, cause, addr, inDelay, wordAcc, output fault_address, fault_status);
endinterface : fault_if

// *** gpr_file.sv ***
// thirty-two word general register file, one write and two read ports
// assumes contents come from configuration load and are never reset
`timescale 1ns/100ps
module gpr_file (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [4:0] rdAddrA,
	input wire logic [4:0] rdAddrB,
	output logic [0:31] rdDataA,
	output logic [0:31] rdDataB,
	input wire logic wrEn,
	input wire logic [4:0] wrAddr,
	input wire logic [0:31] wrData
);
	logic [0:31] mem [0:31];

	// contents set at configuration load only
	initial begin
		for (int i = 0; i < 32; i++) begin
			mem[i] = arch_state_pkg::GPR_INIT;
		end
	end

	// writes to the zero register are dropped
	always_ff @(posedge ref_clk) begin
		if (wrEn && wrAddr != arch_state_pkg::ZERO_REG) begin
			mem[wrAddr] <= wrData;
		end
	end

	// registered reads, the zero register forced to zero
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdDataA <= '0;
			rdDataB <= '0;
		end else begin
			rdDataA <= (rdAddrA == arch_state_pkg::ZERO_REG) ? '0 : mem[rdAddrA];
			rdDataB <= (rdAddrB == arch_state_pkg::ZERO_REG) ? '0 : mem[rdAddrB];
		end
	end

	AST_R0_ZERO: assert property (@(posedge ref_clk) disable iff (!rstn)
		rdAddrA == arch_state_pkg::ZERO_REG |=> rdDataA == '0)
		else $error("zero register read nonzero");
endmodule : gpr_file

// *** fault_capture.sv ***
// fault address and fault status registers
// assumes the core only raises take for an accepted exception
`timescale 1ns/100ps
module fault_capture (
	input wire logic ref_clk,
	input wire logic rstn,
	fault_if.capt flt
);
	logic [0:31] ear_q;
	logic [0:31] esr_q;

	// address captured only for address-bearing causes
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ear_q <= arch_state_pkg::EAR_RST;
		end else if (flt.take && arch_state_pkg::capturesAddr(flt.cause)) begin
			ear_q <= flt.addr;
		end
	end

	// status: delay slot, width flag for unaligned, cause code
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			esr_q <= arch_state_pkg::ESR_RST;
		end else if (flt.take) begin
			esr_q <= '0;
			esr_q[arch_state_pkg::DS_B] <= flt.inDelay;
			esr_q[arch_state_pkg::WACC_B] <= flt.wordAcc
				&& flt.cause == arch_state_pkg::CAUSE_UNALIGN;
			esr_q[arch_state_pkg::EC_LO:arch_state_pkg::EC_HI] <= flt.cause;
		end
	end

	assign flt.fault_address = ear_q;
	assign flt.fault_status = esr_q;

	AST_EAR_CAPT: assert property (@(posedge ref_clk) disable iff (!rstn)
		flt.take && arch_state_pkg::capturesAddr(flt.cause) |=> ear_q == $past(flt.addr))
		else $error("fault address not captured");
	AST_DS_FLAG: assert property (@(posedge ref_clk) disable iff (!rstn)
		flt.take |=> esr_q[arch_state_pkg::DS_B] == $past(flt.inDelay)
			&& esr_q[arch_state_pkg::EC_LO:arch_state_pkg::EC_HI] == $past(flt.cause))
		else $error("fault status mismatch");
endmodule : fault_capture

// *** soft_cpu_arch_state_regs.sv ***
// architectural state of the soft processor: register file, program counter,
// machine status, fault address and fault status, with special register access
// assumes the execution pipeline drives all requests on ref_clk
`timescale 1ns/100ps
module soft_cpu_arch_state_regs #(
	parameter int MMU_CFG = 0,
	parameter bit HW_EXC_CFG = 1'b1,
	parameter bit DCACHE_CFG = 1'b1,
	parameter bit ICACHE_CFG = 1'b1,
	parameter bit DIV_CFG = 1'b1,
	parameter bit STREAM_CFG = 1'b1,
	parameter bit PVR_CFG = 1'b0
) (
	input wire logic ref_clk,
	input wire logic rstn,
	// general register ports
	input wire logic [4:0] rdAddrA,
	input wire logic [4:0] rdAddrB,
	output logic [0:31] rdDataA,
	output logic [0:31] rdDataB,
	input wire logic gprWrEn,
	input wire logic [4:0] gprWrAddr,
	input wire logic [0:31] gprWrData,
	// program counter
	input wire logic pcLoad,
	input wire logic [0:31] pcNext,
	output logic [0:31] pcValue,
	// special register access
	input wire logic mfsEn,
	input wire logic [15:0] rdSel,
	output logic [0:31] sprRdData,
	output logic sprRdValid,
	input wire logic mtsEn,
	input wire logic [15:0] wrSel,
	input wire logic [0:31] mtsData,
	input wire logic msrSetEn,
	input wire logic msrClrEn,
	input wire logic [0:31] msrMask,
	// arithmetic carry and status events
	input wire logic carryWrEn,
	input wire logic carryIn,
	input wire logic divFault,
	input wire logic streamErr,
	// interrupts, breaks and exceptions
	input wire logic intTaken,
	input wire logic brkTaken,
	input wire logic [0:31] retAddr,
	input wire logic excTaken,
	input wire logic [4:0] excCause,
	input wire logic [0:31] excAddr,
	input wire logic excInDelay,
	input wire logic excWordAcc,
	output logic excAllowed,
	// live status controls
	output logic carryEff,
	output logic interruptsOn,
	output logic exceptionsOn,
	output logic excActive,
	output logic breakActive,
	output logic userMode,
	output logic vmOn,
	output logic dcacheOn,
	output logic icacheOn
);
	logic [0:31] msr_q;
	logic [0:31] msr_d;
	logic [0:31] pc_q;
	logic [0:31] rdData_q;
	logic rdValid_q;
	logic [0:31] msrRd;
	logic mtsMsr;
	logic excOk;
	logic wrEn;
	logic [4:0] wrAddr;
	logic [0:31] wrData;

	// mask with only the carry bit set; unused, the writable bits come from WR_MASK
	function automatic logic [0:31] writableMask();
		logic [0:31] m;
		m = '0;
		m[C_B_()] = 1'b1;
		return m;
	endfunction : writableMask

	function automatic int C_B_();
		return arch_state_pkg::C_B;
	endfunction : C_B_

	localparam logic EXC_PRESENT = HW_EXC_CFG || MMU_CFG > 0;
	localparam logic [0:31] WR_MASK = {
		1'b0, 16'h0000,
		1'(MMU_CFG > 1), 1'(MMU_CFG > 1),
		1'(MMU_CFG > 0), 1'(MMU_CFG > 0),
		1'b0,
		EXC_PRESENT, EXC_PRESENT,
		DCACHE_CFG, DIV_CFG, ICACHE_CFG, STREAM_CFG,
		1'b1, 1'b1, 1'b1,
		1'b0
	};
	localparam logic [0:31] MSR_RST_V = arch_state_pkg::MSR_RST
		| ({32{PVR_CFG}} & (32'h80000000 >> arch_state_pkg::PVR_B));

	assign mtsMsr = mtsEn && wrSel == arch_state_pkg::SEL_MSR;

	// accepted exception: memory management causes bypass the enable
	assign excAllowed = EXC_PRESENT
		&& (msr_q[arch_state_pkg::EE_B] || excCause[4]);
	assign excOk = excTaken && EXC_PRESENT;

	// next status value: carry event first, then writes, other hardware events last so sets win
	always_comb begin
		msr_d = msr_q;
		if (carryWrEn) begin
			msr_d[arch_state_pkg::C_B] = carryIn;
		end
		if (mtsMsr) begin
			msr_d = (msr_q & ~WR_MASK) | (mtsData & WR_MASK);
		end else if (msrSetEn) begin
			msr_d = msr_q | (msrMask & WR_MASK);
		end else if (msrClrEn) begin
			msr_d = msr_q & ~(msrMask & WR_MASK);
		end
		if (excOk) begin
			msr_d[arch_state_pkg::EIP_B] = 1'b1;
		end
		if (brkTaken) begin
			msr_d[arch_state_pkg::BIP_B] = 1'b1;
		end
		if (divFault && DIV_CFG) begin
			msr_d[arch_state_pkg::DZO_B] = 1'b1;
		end
		if (streamErr && STREAM_CFG) begin
			msr_d[arch_state_pkg::STE_B] = 1'b1;
		end
		msr_d[arch_state_pkg::CC_B] = 1'b0;
		msr_d[arch_state_pkg::PVR_B] = PVR_CFG;
		msr_d[arch_state_pkg::RSV_B] = 1'b0;
	end

	// status register
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			msr_q <= MSR_RST_V;
		end else begin
			msr_q <= msr_d;
		end
	end

	// program counter, never written by special writes
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pc_q <= arch_state_pkg::PC_RST;
		end else if (pcLoad) begin
			pc_q <= pcNext;
		end
	end

	// status as read: carry mirrored into bit 0
	always_comb begin
		msrRd = msr_q;
		msrRd[arch_state_pkg::CC_B] = msr_q[arch_state_pkg::C_B];
	end

	fault_if flt ();

	// special register reads, answered one cycle after the request
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdData_q <= '0;
			rdValid_q <= 1'b0;
		end else begin
			rdValid_q <= mfsEn;
			if (mfsEn) begin
				unique case (rdSel)
					arch_state_pkg::SEL_PC: rdData_q <= pc_q;
					arch_state_pkg::SEL_MSR: rdData_q <= msrRd;
					arch_state_pkg::SEL_EAR: rdData_q <= flt.fault_address;
					arch_state_pkg::SEL_ESR: rdData_q <= flt.fault_status;
					default: rdData_q <= '0;
				endcase
			end
		end
	end

	assign sprRdData = rdData_q;
	assign sprRdValid = rdValid_q;

	// carry visible at once for set and clear, otherwise from the register
	assign carryEff = (msrSetEn || msrClrEn) && !mtsMsr
		? msr_d[arch_state_pkg::C_B] : msr_q[arch_state_pkg::C_B];
	assign interruptsOn = msr_q[arch_state_pkg::IE_B];
	assign exceptionsOn = msr_q[arch_state_pkg::EE_B];
	assign excActive = msr_q[arch_state_pkg::EIP_B];
	assign breakActive = msr_q[arch_state_pkg::BIP_B];
	assign userMode = msr_q[arch_state_pkg::UM_B];
	assign vmOn = msr_q[arch_state_pkg::VM_B];
	assign dcacheOn = msr_q[arch_state_pkg::DCE_B];
	assign icacheOn = msr_q[arch_state_pkg::ICE_B];
	assign pcValue = pc_q;

	// fault capture feed
	assign flt.take = excOk;
	assign flt.cause = excCause;
	assign flt.addr = excAddr;
	assign flt.inDelay = excInDelay;
	assign flt.wordAcc = excWordAcc;

	fault_capture u_fault (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.flt(flt.capt)
	);

	// register file write: return addresses take priority over the pipeline
	always_comb begin
		wrEn = gprWrEn;
		wrAddr = gprWrAddr;
		wrData = gprWrData;
		if (excOk && HW_EXC_CFG) begin
			wrEn = 1'b1;
			wrAddr = arch_state_pkg::EXC_RET_REG;
			wrData = retAddr;
		end else if (brkTaken) begin
			wrEn = 1'b1;
			wrAddr = arch_state_pkg::BRK_RET_REG;
			wrData = retAddr;
		end else if (intTaken) begin
			wrEn = 1'b1;
			wrAddr = arch_state_pkg::INT_RET_REG;
			wrData = retAddr;
		end
	end

	gpr_file u_gpr (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.rdAddrA(rdAddrA),
		.rdAddrB(rdAddrB),
		.rdDataA(rdDataA),
		.rdDataB(rdDataB),
		.wrEn(wrEn),
		.wrAddr(wrAddr),
		.wrData(wrData)
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	AST_PC_NO_MTS: assert property (
		mtsEn && wrSel == arch_state_pkg::SEL_PC && !pcLoad |=> pc_q == $past(pc_q))
		else $error("program counter changed by special write");
	AST_PC_READ: assert property (
		mfsEn && rdSel == arch_state_pkg::SEL_PC |=> sprRdValid && sprRdData == $past(pc_q))
		else $error("program counter read wrong");
	AST_CC_MIRROR: assert property (
		mfsEn && rdSel == arch_state_pkg::SEL_MSR |=> sprRdData[0] == sprRdData[29])
		else $error("carry copy differs from carry");
	AST_SET_CARRY_NOW: assert property (
		msrSetEn && !mtsMsr && msrMask[arch_state_pkg::C_B] |-> carryEff)
		else $error("carry not immediate on set");
	AST_MTS_LATER: assert property (
		mtsMsr && !brkTaken ##0 interruptsOn != mtsData[arch_state_pkg::IE_B]
			|-> ##1 interruptsOn == $past(mtsData[arch_state_pkg::IE_B]))
		else $error("status write not applied next cycle");
	AST_PVR_CONST: assert property (
		msr_q[arch_state_pkg::PVR_B] == PVR_CFG)
		else $error("version presence bit changed");
	AST_DZO_SET: assert property (
		divFault && DIV_CFG |=> msr_q[arch_state_pkg::DZO_B])
		else $error("divide fault flag not set");
	AST_STREAM_STICKY: assert property (
		msr_q[arch_state_pkg::STE_B] && !mtsMsr && !msrClrEn |=> msr_q[arch_state_pkg::STE_B])
		else $error("stream error flag lost");
	AST_BIP_SET: assert property (
		brkTaken |=> breakActive)
		else $error("break flag not set");
	AST_RSV_ZERO: assert property (
		msr_q[arch_state_pkg::RSV_B] == 1'b0 && msr_q[1:16] == 16'h0000)
		else $error("reserved status bits set");
endmodule : soft_cpu_arch_state_regs

// *** pipeline_model.sv ***
// pipeline side model: register file, special register and status event requests
// assumes the bench calls its tasks one ns after a ref_clk rising edge
`timescale 1ns/100ps
module pipeline_model (
	input wire logic ref_clk,
	input wire logic [0:31] rdDataA,
	input wire logic [0:31] rdDataB,
	input wire logic [0:31] sprRdData,
	input wire logic sprRdValid,
	output logic [4:0] rdAddrA,
	output logic [4:0] rdAddrB,
	output logic gprWrEn,
	output logic [4:0] gprWrAddr,
	output logic [0:31] gprWrData,
	output logic pcLoad,
	output logic [0:31] pcNext,
	output logic mfsEn,
	output logic [15:0] rdSel,
	output logic mtsEn,
	output logic [15:0] wrSel,
	output logic [0:31] mtsData,
	output logic msrSetEn,
	output logic msrClrEn,
	output logic [0:31] msrMask,
	output logic carryWrEn,
	output logic carryIn,
	output logic divFault,
	output logic streamErr,
	output logic intTaken,
	output logic brkTaken,
	output logic [0:31] retAddr,
	output logic excTaken,
	output logic [4:0] excCause,
	output logic [0:31] excAddr,
	output logic excInDelay,
	output logic excWordAcc
);
	// strobes are single-edge pulses, dropped on the edge that takes them so that
	// a following request may raise them again one ns later without a clash
	task automatic step();
		@(posedge ref_clk);
		{gprWrEn, pcLoad, mfsEn, mtsEn, msrSetEn, msrClrEn} <= '0;
		{carryWrEn, divFault, streamErr, intTaken, brkTaken, excTaken} <= '0;
		#1;
	endtask : step
	// every request line starts quiet
	initial begin
		{rdAddrA, rdAddrB, gprWrAddr, gprWrData, pcNext, rdSel, wrSel, mtsData} = '0;
		{msrMask, carryIn, retAddr, excCause, excAddr, excInDelay, excWordAcc} = '0;
		{gprWrEn, pcLoad, mfsEn, mtsEn, msrSetEn, msrClrEn} = '0;
		{carryWrEn, divFault, streamErr, intTaken, brkTaken, excTaken} = '0;
	end
	// special read: answer stands in the cycle after the request edge
	task automatic readSpr(input logic [15:0] sel, output logic [0:31] d, output logic v);
		mfsEn = 1'b1;
		rdSel = sel;
		step();
		d = sprRdData;
		v = sprRdValid;
	endtask : readSpr
	// both read ports look at one register, answer one edge later
	task automatic readGpr(input logic [4:0] a, output logic [0:31] da, output logic [0:31] db);
		rdAddrA = a;
		rdAddrB = a;
		step();
		da = rdDataA;
		db = rdDataB;
	endtask : readGpr
	task automatic writeGpr(input logic [4:0] a, input logic [0:31] d);
		gprWrEn = 1'b1;
		gprWrAddr = a;
		gprWrData = d;
		step();
	endtask : writeGpr
	task automatic writeSpr(input logic [15:0] sel, input logic [0:31] d);
		mtsEn = 1'b1;
		wrSel = sel;
		mtsData = d;
		step();
	endtask : writeSpr
	task automatic loadPc(input logic [0:31] a);
		pcLoad = 1'b1;
		pcNext = a;
		step();
	endtask : loadPc
	// set or clear request, left standing so the bench can look before the edge
	task automatic modMsr(input logic s, input logic [0:31] m);
		msrSetEn = s;
		msrClrEn = ~s;
		msrMask = m;
		#1;
	endtask : modMsr
	task automatic flags(input logic cw, input logic ci, input logic dv, input logic se);
		carryWrEn = cw;
		carryIn = ci;
		divFault = dv;
		streamErr = se;
	endtask : flags
	// interrupt, break and exception events; k is {int, brk, exc}
	task automatic trap(input logic [2:0] k, input logic [0:31] ra, input logic [4:0] c,
			input logic [0:31] a, input logic ds, input logic w);
		{intTaken, brkTaken, excTaken} = k;
		retAddr = ra;
		excCause = c;
		excAddr = a;
		excInDelay = ds;
		excWordAcc = w;
		#1;
	endtask : trap
endmodule : pipeline_model

// *** test_soft_cpu_arch_state_regs.sv ***
// self-checking bench for the architectural state block
// assumes default configuration: no memory management; exceptions, caches, divider and stream present
`timescale 1ns/100ps
module test_soft_cpu_arch_state_regs;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic [4:0] rdAddrA, rdAddrB, gprWrAddr, excCause;
	logic [0:31] rdDataA, rdDataB, gprWrData, pcNext, pcValue, sprRdData, mtsData;
	logic [0:31] msrMask, retAddr, excAddr, d, db, fault_address;
	logic [15:0] rdSel, wrSel;
	logic gprWrEn, pcLoad, mfsEn, sprRdValid, mtsEn, msrSetEn, msrClrEn, carryWrEn, carryIn;
	logic divFault, streamErr, intTaken, brkTaken, excTaken, excInDelay, excWordAcc;
	logic excAllowed, carryEff, interruptsOn, exceptionsOn, excActive, breakActive;
	logic userMode, vmOn, dcacheOn, icacheOn, v;
	logic [4:0] causes [13] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
		5'h10, 5'h11, 5'h12, 5'h13, 5'h01};
	int miscompares = 0;
	int checked = 0;

	soft_cpu_arch_state_regs i_dut (.ref_clk, .rstn, .rdAddrA, .rdAddrB, .rdDataA, .rdDataB,
		.gprWrEn, .gprWrAddr, .gprWrData, .pcLoad, .pcNext, .pcValue, .mfsEn, .rdSel,
		.sprRdData, .sprRdValid, .mtsEn, .wrSel, .mtsData, .msrSetEn, .msrClrEn, .msrMask,
		.carryWrEn, .carryIn, .divFault, .streamErr, .intTaken, .brkTaken, .retAddr,
		.excTaken, .excCause, .excAddr, .excInDelay, .excWordAcc, .excAllowed, .carryEff,
		.interruptsOn, .exceptionsOn, .excActive, .breakActive, .userMode, .vmOn,
		.dcacheOn, .icacheOn);
	pipeline_model i_pipe (.ref_clk, .rdDataA, .rdDataB, .sprRdData, .sprRdValid, .rdAddrA,
		.rdAddrB, .gprWrEn, .gprWrAddr, .gprWrData, .pcLoad, .pcNext, .mfsEn, .rdSel, .mtsEn,
		.wrSel, .mtsData, .msrSetEn, .msrClrEn, .msrMask, .carryWrEn, .carryIn, .divFault,
		.streamErr, .intTaken, .brkTaken, .retAddr, .excTaken, .excCause, .excAddr,
		.excInDelay, .excWordAcc);

	// 125 MHz core clock
	always #4 ref_clk = ~ref_clk;

	task automatic check(input logic [0:31] seen, input logic [0:31] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test
	// special read with its one-cycle valid pulse
	task automatic chkSpr(input logic [15:0] sel, input logic [0:31] exp);
		i_pipe.readSpr(sel, d, v);
		check(v, 1'b1);
		check(d, exp);
	endtask : chkSpr

	task automatic test_reset();
		chkSpr(arch_state_pkg::SEL_PC, 32'h00000000);
		chkSpr(arch_state_pkg::SEL_MSR, 32'h00000000);
		chkSpr(arch_state_pkg::SEL_EAR, 32'h00000000);
		chkSpr(arch_state_pkg::SEL_ESR, 32'h00000000);
		chkSpr(16'h0002, 32'h00000000);
		check({dcacheOn, icacheOn}, 2'b00);
		$display("test_reset done");
	endtask : test_reset
	// register zero discards writes; a mid-run reset leaves the file alone
	task automatic test_gpr();
		i_pipe.writeGpr(5'h05, 32'h12345678);
		i_pipe.writeGpr(5'h00, 32'hdeadbeef);
		i_pipe.readGpr(5'h05, d, db);
		check(d, 32'h12345678);
		check(db, 32'h12345678);
		i_pipe.readGpr(5'h00, d, db);
		check(d, 32'h00000000);
		check(db, 32'h00000000);
		rstn = 1'b0;
		i_pipe.step();
		rstn = 1'b1;
		i_pipe.step();
		i_pipe.readGpr(5'h05, d, db);
		check(d, 32'h12345678);
		$display("test_gpr done");
	endtask : test_gpr
	task automatic test_pc();
		i_pipe.loadPc(32'h00001234);
		i_pipe.writeSpr(arch_state_pkg::SEL_PC, 32'hffffffff);
		chkSpr(arch_state_pkg::SEL_PC, 32'h00001234);
		check(pcValue, 32'h00001234);
		$display("test_pc done");
	endtask : test_pc
	// all-ones write: only configured writable bits land, bit 0 mirrors carry
	task automatic test_mts();
		i_pipe.writeSpr(arch_state_pkg::SEL_MSR, 32'hffffffff);
		check({interruptsOn, exceptionsOn, excActive, breakActive}, 4'hf);
		check({dcacheOn, icacheOn}, 2'b11);
		check({userMode, vmOn}, 2'b00);
		chkSpr(arch_state_pkg::SEL_MSR, 32'h800003fe);
		i_pipe.writeSpr(arch_state_pkg::SEL_MSR, 32'h80000000);
		chkSpr(arch_state_pkg::SEL_MSR, 32'h00000000);
		check(interruptsOn, 1'b0);
		$display("test_mts done");
	endtask : test_mts
	task automatic test_setclr();
		i_pipe.modMsr(1'b1, 32'h00000006);
		check(carryEff, 1'b1);
		check(interruptsOn, 1'b0);
		i_pipe.step();
		check(interruptsOn, 1'b1);
		chkSpr(arch_state_pkg::SEL_MSR, 32'h80000006);
		i_pipe.modMsr(1'b0, 32'h00000006);
		check(carryEff, 1'b0);
		i_pipe.step();
		i_pipe.flags(1'b1, 1'b1, 1'b0, 1'b0);
		i_pipe.step();
		chkSpr(arch_state_pkg::SEL_MSR, 32'h80000004);
		$display("test_setclr done");
	endtask : test_setclr
	// divide and stream flags, sticky clear, return address registers
	task automatic test_events();
		i_pipe.writeSpr(arch_state_pkg::SEL_MSR, 32'h00000000);
		i_pipe.flags(1'b0, 1'b0, 1'b1, 1'b1);
		i_pipe.step();
		i_pipe.step();
		chkSpr(arch_state_pkg::SEL_MSR, 32'h00000050);
		i_pipe.modMsr(1'b0, 32'h00000010);
		i_pipe.step();
		chkSpr(arch_state_pkg::SEL_MSR, 32'h00000040);
		i_pipe.trap(3'b100, 32'h00000100, 5'h00, 32'h0, 1'b0, 1'b0);
		i_pipe.step();
		i_pipe.trap(3'b010, 32'h00000200, 5'h00, 32'h0, 1'b0, 1'b0);
		i_pipe.step();
		check(breakActive, 1'b1);
		i_pipe.readGpr(5'h0e, d, db);
		check(d, 32'h00000100);
		i_pipe.readGpr(5'h10, d, db);
		check(d, 32'h00000200);
		$display("test_events done");
	endtask : test_events
	// every cause code, delay slot toggling, word and halfword unaligned
	task automatic test_exc();
		logic [4:0] c;
		i_pipe.writeSpr(arch_state_pkg::SEL_MSR, 32'h00000000);
		i_pipe.trap(3'b000, 32'h0, 5'h10, 32'h0, 1'b0, 1'b0);
		check(excAllowed, 1'b1);
		i_pipe.trap(3'b000, 32'h0, 5'h01, 32'h0, 1'b0, 1'b0);
		check(excAllowed, 1'b0);
		fault_address = 32'h00000000;
		for (int i = 0; i < 13; i++) begin
			c = causes[i];
			i_pipe.trap(3'b001, 32'h3000 + i, c, 32'h5000 + i, i[0], i < 12);
			i_pipe.step();
			if (c == 5'h01 || c == 5'h04 || c[4]) begin
				fault_address = 32'h5000 + i;
			end
			chkSpr(arch_state_pkg::SEL_EAR, fault_address);
			chkSpr(arch_state_pkg::SEL_ESR, {19'h0, i[0], c == 5'h01 && i < 12, 6'h0, c});
			i_pipe.readGpr(5'h11, d, db);
			check(d, 32'h3000 + i);
		end
		check(excActive, 1'b1);
		$display("test_exc done");
	endtask : test_exc

	// main sequence: reset for twelve cycles, then each scenario
	initial begin
		repeat (12) @(posedge ref_clk);
		#1;
		rstn = 1'b1;
		i_pipe.step();
		test_reset();
		test_gpr();
		test_pc();
		test_mts();
		test_setclr();
		test_events();
		test_exc();
		finish_test();
	end
	// watchdog: the scenarios need about a hundred cycles
	initial begin
		#(3000 * 8);
		miscompares++;
		finish_test();
	end
endmodule : test_soft_cpu_arch_state_regs
